// ---- hw/dgo_defs.svh ----
// Constants for the DAC gain/offset correction and update controller.
// Assumes a 100 MHz core clock; all times are in ns and converted here.
`ifndef DGO_DEFS_SVH
`define DGO_DEFS_SVH

// Channel count and word layout
`define DGO_NUM_CH      32
`define DGO_GAIN_SHIFT  13
`define DGO_WORD_MAX    14'h3fff
`define DGO_WORD_MIN    14'h0000

// Reset values of the per-channel registers, and the offset bias
`define DGO_INPUT_DEF   14'h2000
`define DGO_TRIM_DEF    14'h2000
`define DGO_GAIN_DEF    13'h1fff
`define DGO_OFFS_DEF    14'h2000
`define DGO_OFFS_BIAS   17'h02000

// Destination select codes {hi, lo}
`define DGO_DEST_INPUT  2'h3
`define DGO_DEST_OFFS   2'h2
`define DGO_DEST_GAIN   2'h1
`define DGO_DEST_SFR    2'h0

// Timing: clock period, per-channel calculation, queue overhead
`define DGO_CLK_NS      10
`define DGO_CALC_NS     150
`define DGO_QOVH_NS     200
`define DGO_CALC_CYC    ((`DGO_CALC_NS + `DGO_CLK_NS - 1) / `DGO_CLK_NS)
`define DGO_QOVH_CYC    ((`DGO_QOVH_NS + `DGO_CLK_NS - 1) / `DGO_CLK_NS)

// Longest busy time for one channel, without and with the queue
`define DGO_BUSY1_NS    330
`define DGO_BUSY1Q_NS   530
`define DGO_BUSY1_CYC   (`DGO_BUSY1_NS / `DGO_CLK_NS)
`define DGO_BUSY1Q_CYC  (`DGO_BUSY1Q_NS / `DGO_CLK_NS)

`endif

// ---- hw/dgo_pkg.sv ----
// Types for the DAC gain/offset correction and update controller.
// Constants live in dgo_defs.svh.
package dgo_pkg;

  typedef logic [13:0] dgo_word_t;
  typedef logic [12:0] dgo_coef_t;
  typedef logic [4:0]  dgo_chan_t;

  // Calculation engine states, Gray coded along idle-overhead-calc-store
  typedef enum logic [1:0]
  {
    S_IDLE  = 2'b00,
    S_OVH   = 2'b01,
    S_CALC  = 2'b11,
    S_STORE = 2'b10
  } dgo_state_t;

endpackage

// ---- hw/dgo_cycle_timer.sv ----
// Down-counter that pulses done a programmed number of cycles after start.
// Assumes start is a one-cycle pulse from the engine.
`timescale 1ns/1ps
module dgo_cycle_timer
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Control
  input  wire logic       start,
  input  wire logic [7:0] load,
  output logic            done
);

  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       next_done;

  // Count down, flag the last step
  always_comb
  begin
    next_cnt  = cnt;
    next_done = 1'b0;
    if (start)
      next_cnt = load;
    else if (cnt != 8'h00)
    begin
      next_cnt  = cnt - 8'h01;
      next_done = (cnt == 8'h01);
    end
  end

  // Register the counter state
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt  <= 8'h00;
      done <= 1'b0;
    end
    else
    begin
      cnt  <= next_cnt;
      done <= next_done;
    end
  end

endmodule

// ---- hw/dgo_trim_calc.sv ----
// Registered gain/offset correction of one channel word with saturation.
// Assumes inputs are held stable by the engine for the calculation time.
`timescale 1ns/1ps
`include "dgo_defs.svh"
module dgo_trim_calc
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Operands
  input  wire dgo_pkg::dgo_word_t input_word,
  input  wire dgo_pkg::dgo_coef_t gain,
  input  wire dgo_pkg::dgo_word_t offset,
  // Result
  output dgo_pkg::dgo_word_t      trimmed_word
);
  import dgo_pkg::*;

  logic [27:0]        prod;
  logic [14:0]        scaled;
  logic signed [16:0] sum;
  dgo_word_t          next_trimmed;

  // Scale by (gain+1)/2^13, drop the fraction, then add offset less bias
  always_comb
  begin
    prod   = 28'({1'b0, gain} + 14'h0001) * 28'(input_word);
    scaled = prod[27:`DGO_GAIN_SHIFT];
    sum    = $signed({2'b00, scaled}) + $signed({3'b000, offset}) - $signed(`DGO_OFFS_BIAS);
    // Clamp instead of wrapping
    if (sum < 0)
      next_trimmed = `DGO_WORD_MIN;
    else if (sum > $signed({3'b000, `DGO_WORD_MAX}))
      next_trimmed = `DGO_WORD_MAX;
    else
      next_trimmed = sum[13:0];
  end

  // Register the result
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      trimmed_word <= `DGO_TRIM_DEF;
    else
      trimmed_word <= next_trimmed;
  end

  chk_sat_high: assert property (@(posedge clk) disable iff (!arst_n)
    (sum > $signed({3'b000, `DGO_WORD_MAX})) |=> (trimmed_word == `DGO_WORD_MAX))
    else $error("overflow not clamped to full scale");
  chk_sat_low: assert property (@(posedge clk) disable iff (!arst_n)
    (sum < 0) |=> (trimmed_word == `DGO_WORD_MIN))
    else $error("underflow not clamped to zero");
  chk_unity_default: assert property (@(posedge clk) disable iff (!arst_n)
    (gain == `DGO_GAIN_DEF && offset == `DGO_OFFS_DEF) |=> (trimmed_word == $past(input_word)))
    else $error("default gain and offset do not pass the word through");

endmodule

// ---- hw/dgo_update_ctrl.sv ----
// Per-channel correction and output update control for a 32-channel DAC.
// Assumes host strobes are synchronous to MCLK; the busy pin is wired open-drain outside.
`timescale 1ns/1ps
`include "dgo_defs.svh"
module dgo_update_ctrl
(
  // Clock and reset
  input  wire logic               MCLK,
  input  wire logic               ARST_N,
  // Host write port
  input  wire logic               WR_STB,
  input  wire logic               DEST_SELECT_HI,
  input  wire logic               DEST_SELECT_LO,
  input  wire logic               WR_ALL,
  input  wire dgo_pkg::dgo_chan_t WR_CHAN,
  input  wire dgo_pkg::dgo_word_t WR_DATA,
  input  wire logic               QUEUE_EN,
  // Output control strobes
  input  wire logic               OUTPUT_FORCE_GROUND_N,
  input  wire logic               LOAD_OUTPUTS_N,
  // Open-drain busy pin
  input  wire logic               BUSY_N_IN,
  output logic                    BUSY_N_OUT,
  output logic                    BUSY_N_OE_N,
  // Output state
  input  wire dgo_pkg::dgo_chan_t DAC_RD_CHAN,
  output dgo_pkg::dgo_word_t      DAC_RD_WORD,
  output logic                    OUTPUT_GROUND_REF,
  output logic                    UPDATE_DONE
);
  import dgo_pkg::*;

  localparam int CALC_BND  = `DGO_CALC_CYC + 2;
  localparam int BUSY_BND  = `DGO_BUSY1_CYC;
  localparam int BUSYQ_BND = `DGO_BUSY1Q_CYC;

  // Per-channel storage
  dgo_word_t  input_word [`DGO_NUM_CH];
  dgo_coef_t  gain       [`DGO_NUM_CH];
  dgo_word_t  offset     [`DGO_NUM_CH];
  dgo_word_t  trimmed_word [`DGO_NUM_CH];
  dgo_word_t  dac        [`DGO_NUM_CH];

  logic [31:0] dirty;
  logic [31:0] next_dirty;
  logic [31:0] changed;
  logic [31:0] next_changed;
  logic [31:0] wr_mask;
  dgo_state_t  state;
  dgo_state_t  next_state;
  dgo_chan_t   ch;
  dgo_chan_t   next_ch;
  logic        pending;
  logic        next_pending;
  logic        next_ground;
  logic        tmr_start;
  logic [7:0]  tmr_load;
  logic        tmr_done;
  logic        store;
  logic        wr_coef;
  logic        busy_int;
  logic        line_busy;
  logic        upd_go;
  dgo_word_t   calc_out;
  logic [1:0]  dest;

  // Lowest channel waiting for recalculation
  function automatic dgo_chan_t first_dirty(input logic [31:0] v);
    dgo_chan_t f;
    f = 5'h00;
    for (int i = `DGO_NUM_CH - 1; i >= 0; i--)
      if (v[i])
        f = 5'(i);
    return f;
  endfunction

  // Write decode and busy terms
  assign dest      = {DEST_SELECT_HI, DEST_SELECT_LO};
  assign wr_coef   = WR_STB && (dest != `DGO_DEST_SFR);
  assign wr_mask   = WR_ALL ? 32'hffffffff : (32'h00000001 << WR_CHAN);
  assign busy_int  = (state != S_IDLE) || (|dirty);
  assign line_busy = busy_int || !BUSY_N_IN;
  assign upd_go    = OUTPUT_FORCE_GROUND_N && !line_busy
                     && (pending || !LOAD_OUTPUTS_N);

  // Calculation engine: walk dirty channels one at a time
  always_comb
  begin
    next_state = state;
    next_ch    = ch;
    next_dirty = dirty;
    tmr_start  = 1'b0;
    tmr_load   = 8'(`DGO_CALC_CYC);
    store      = 1'b0;
    case (state)
      S_IDLE:
      begin
        if (|dirty)
        begin
          next_ch             = first_dirty(dirty);
          next_dirty[next_ch] = 1'b0;
          tmr_start           = 1'b1;
          if (QUEUE_EN)
          begin
            tmr_load   = 8'(`DGO_QOVH_CYC);
            next_state = S_OVH;
          end
          else
            next_state = S_CALC;
        end
      end
      S_OVH:
      begin
        if (tmr_done)
        begin
          tmr_start  = 1'b1;
          next_state = S_CALC;
        end
      end
      S_CALC:
      begin
        if (tmr_done)
          next_state = S_STORE;
      end
      S_STORE:
      begin
        store = 1'b1;
        if (|dirty)
        begin
          next_ch             = first_dirty(dirty);
          next_dirty[next_ch] = 1'b0;
          tmr_start           = 1'b1;
          next_state          = S_CALC;
        end
        else
          next_state = S_IDLE;
      end
      default:
      begin
        next_state = S_IDLE;
      end
    endcase
    // A new write wins over the clear of its dirty bit
    if (wr_coef)
      next_dirty = next_dirty | wr_mask;
  end

  // Engine registers
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state <= S_IDLE;
      ch    <= 5'h00;
      dirty <= 32'h00000000;
    end
    else
    begin
      state <= next_state;
      ch    <= next_ch;
      dirty <= next_dirty;
    end
  end

  // Load request, clear and changed-channel tracking
  always_comb
  begin
    next_changed = changed;
    next_pending = pending;
    next_ground  = OUTPUT_GROUND_REF;
    if (upd_go)
      next_changed = 32'h00000000;
    if (store)
      next_changed[ch] = 1'b1;
    if (!OUTPUT_FORCE_GROUND_N)
    begin
      next_pending = 1'b0;
      next_ground  = 1'b1;
    end
    else if (upd_go)
    begin
      next_pending = 1'b0;
      next_ground  = 1'b0;
    end
    else if (!LOAD_OUTPUTS_N && line_busy)
      next_pending = 1'b1;
  end

  // Control and output registers
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      changed           <= 32'h00000000;
      pending           <= 1'b0;
      OUTPUT_GROUND_REF <= 1'b1;
      UPDATE_DONE       <= 1'b0;
      BUSY_N_OE_N       <= 1'b1;
      BUSY_N_OUT        <= 1'b0;
      DAC_RD_WORD       <= `DGO_TRIM_DEF;
    end
    else
    begin
      changed           <= next_changed;
      pending           <= next_pending;
      OUTPUT_GROUND_REF <= next_ground;
      UPDATE_DONE       <= upd_go;
      BUSY_N_OE_N       <= !busy_int;
      BUSY_N_OUT        <= 1'b0;
      DAC_RD_WORD       <= dac[DAC_RD_CHAN];
    end
  end

  // Channel register file; clear never touches it
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      for (int k = 0; k < `DGO_NUM_CH; k++)
      begin
        input_word[k]   <= `DGO_INPUT_DEF;
        gain[k]         <= `DGO_GAIN_DEF;
        offset[k]       <= `DGO_OFFS_DEF;
        trimmed_word[k] <= `DGO_TRIM_DEF;
        dac[k]          <= `DGO_TRIM_DEF;
      end
    end
    else
    begin
      for (int k = 0; k < `DGO_NUM_CH; k++)
      begin
        if (wr_coef && wr_mask[k])
        begin
          case (dest)
            `DGO_DEST_INPUT: input_word[k] <= WR_DATA;
            `DGO_DEST_OFFS:  offset[k]     <= WR_DATA;
            `DGO_DEST_GAIN:  gain[k]       <= WR_DATA[12:0];
            default:         input_word[k] <= input_word[k];
          endcase
        end
        if (upd_go && changed[k])
          dac[k] <= trimmed_word[k];
      end
      if (store)
        trimmed_word[ch] <= calc_out;
    end
  end

  // Corrected-word arithmetic for the channel in service
  dgo_trim_calc u_calc
  (
    .clk          (MCLK),
    .arst_n       (ARST_N),
    .input_word   (input_word[ch]),
    .gain         (gain[ch]),
    .offset       (offset[ch]),
    .trimmed_word (calc_out)
  );

  // Overhead and per-channel calculation timing
  dgo_cycle_timer u_timer
  (
    .clk    (MCLK),
    .arst_n (ARST_N),
    .start  (tmr_start),
    .load   (tmr_load),
    .done   (tmr_done)
  );

  // Length of the current busy stretch, for timing checks
  logic [9:0] busy_len;
  logic       multi;
  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      busy_len <= 10'h000;
      multi    <= 1'b0;
    end
    else if (!busy_int)
    begin
      busy_len <= 10'h000;
      multi    <= 1'b0;
    end
    else
    begin
      busy_len <= busy_len + 10'h001;
      multi    <= multi || wr_coef || (WR_ALL && WR_STB) || (state == S_STORE && |dirty);
    end
  end

  chk_clear_forces: assert property (@(posedge MCLK) disable iff (!ARST_N)
    !OUTPUT_FORCE_GROUND_N |=> OUTPUT_GROUND_REF)
    else $error("clear did not ground outputs");
  chk_clear_keeps: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (OUTPUT_GROUND_REF && !upd_go) |=> OUTPUT_GROUND_REF)
    else $error("outputs left ground without a load");
  chk_clear_ignores: assert property (@(posedge MCLK) disable iff (!ARST_N)
    !OUTPUT_FORCE_GROUND_N |=> (!pending && !UPDATE_DONE))
    else $error("load stored or acted on during clear");
  chk_busy_on_write: assert property (@(posedge MCLK) disable iff (!ARST_N)
    wr_coef |-> ##2 !BUSY_N_OE_N)
    else $error("busy not driven after a coefficient write");
  chk_no_busy_update: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (busy_int || !BUSY_N_IN) |=> !UPDATE_DONE)
    else $error("update while busy");
  chk_pending_served: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (pending && OUTPUT_FORCE_GROUND_N && !line_busy) |=> (UPDATE_DONE && !pending))
    else $error("stored load not performed after busy");
  chk_held_load: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (!LOAD_OUTPUTS_N && OUTPUT_FORCE_GROUND_N && !line_busy) |=> UPDATE_DONE)
    else $error("held load did not update outputs");
  chk_copy_changed: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (upd_go && changed[0]) |=> (dac[0] == $past(trimmed_word[0])))
    else $error("changed channel not copied on load");
  chk_skip_same: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (upd_go && !changed[0]) |=> (dac[0] == $past(dac[0])))
    else $error("unchanged channel was reloaded");
  chk_calc_time: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (state == S_CALC && $past(state) != S_CALC) |-> ##[1:CALC_BND] (state == S_STORE))
    else $error("channel calculation took too long");
  chk_busy_one: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (busy_int && !multi) |-> (busy_len < 10'(QUEUE_EN ? BUSYQ_BND : BUSY_BND)))
    else $error("single-channel busy too long");

  cov_update: cover property (@(posedge MCLK) disable iff (!ARST_N) upd_go && |changed);
  cov_pending: cover property (@(posedge MCLK) disable iff (!ARST_N) pending ##[1:200] UPDATE_DONE);
  cov_clear: cover property (@(posedge MCLK) disable iff (!ARST_N)
    !OUTPUT_FORCE_GROUND_N ##1 OUTPUT_FORCE_GROUND_N ##[1:50] UPDATE_DONE);

endmodule

// ---- bench/dgo_host_model.sv ----
// Host controller model: writes channel registers, drives load and clear strobes.
// Assumes the bench calls its tasks; every change lands on a falling MCLK edge.
`timescale 1ns/1ps
module dgo_host_model
(
  // Clock
  input  wire logic          mclk,
  // Write port
  output logic               wr_stb,
  output logic               dest_hi,
  output logic               dest_lo,
  output logic               wr_all,
  output dgo_pkg::dgo_chan_t wr_chan,
  output dgo_pkg::dgo_word_t wr_data,
  output logic               queue_en,
  // Strobes and busy pull
  output logic               force_ground_n,
  output logic               load_n,
  output logic               busy_oe_n
);
  import dgo_pkg::*;

  // Quiet bus at time zero
  initial
  begin
    wr_stb = 1'b0;
    {dest_hi, dest_lo} = 2'h0;
    wr_all = 1'b0;
    wr_chan = 5'h00;
    wr_data = 14'h0000;
    queue_en = 1'b0;
    force_ground_n = 1'b1;
    load_n = 1'b1;
    busy_oe_n = 1'b1;
  end

  // One-cycle write; released address and data are scrambled so stale values never match
  task automatic write(input logic [1:0] dest, input logic all, input dgo_chan_t ch, input dgo_word_t d);
    @(negedge mclk);
    {dest_hi, dest_lo} = dest;
    wr_all = all;
    wr_chan = ch;
    wr_data = d;
    wr_stb = 1'b1;
    @(negedge mclk);
    wr_stb = 1'b0;
    wr_chan = ~ch;
    wr_data = ~d;
  endtask

  // Level strobes and the open-drain busy pull
  task automatic set_load(input logic v);
    @(negedge mclk);
    load_n = v;
  endtask
  task automatic set_clear(input logic v);
    @(negedge mclk);
    force_ground_n = v;
  endtask
  task automatic pull_busy(input logic v);
    @(negedge mclk);
    busy_oe_n = v;
  endtask
  task automatic set_queue(input logic v);
    @(negedge mclk);
    queue_en = v;
  endtask
endmodule

// ---- bench/test_dgo_update_ctrl.sv ----
// Self-checking bench for the DAC correction and update controller.
// Assumes the host model drives the write port; busy wire resolved here with a pull-up.
`timescale 1ns/1ps
`include "dgo_defs.svh"
module test_dgo_update_ctrl;
  import dgo_pkg::*;

  logic       mclk;
  logic       arst_n;
  logic       wr_stb;
  logic       dest_hi;
  logic       dest_lo;
  logic       wr_all;
  dgo_chan_t  wr_chan;
  dgo_word_t  wr_data;
  logic       queue_en;
  logic       force_ground_n;
  logic       load_n;
  logic       host_busy_oe_n;
  logic       busy_n_out;
  logic       busy_n_oe_n;
  logic       busy_n_in;
  dgo_chan_t  rd_chan;
  dgo_word_t  dac_word;
  logic       ground_ref;
  logic       update_done;
  int         n_fail;
  int         total_checks;
  int         cycles;
  int         n_upd;
  int         base;
  int         blen;
  int         blen_nq;
  int         m_in[32];
  int         m_gn[32];
  int         m_of[32];
  int         m_tr[32];
  int         m_dac[32];
  bit         m_dirty[32];

  // Open-drain wire: low if any party pulls, else pulled up
  assign busy_n_in = ((busy_n_oe_n === 1'b0 && busy_n_out === 1'b0) || host_busy_oe_n === 1'b0) ? 1'b0 : 1'b1;

  dgo_host_model u_dgo_host_model
  (
    .mclk           (mclk),
    .wr_stb         (wr_stb),
    .dest_hi        (dest_hi),
    .dest_lo        (dest_lo),
    .wr_all         (wr_all),
    .wr_chan        (wr_chan),
    .wr_data        (wr_data),
    .queue_en       (queue_en),
    .force_ground_n (force_ground_n),
    .load_n         (load_n),
    .busy_oe_n      (host_busy_oe_n)
  );

  dgo_update_ctrl u_dgo_update_ctrl
  (
    .MCLK                  (mclk),
    .ARST_N                (arst_n),
    .WR_STB                (wr_stb),
    .DEST_SELECT_HI        (dest_hi),
    .DEST_SELECT_LO        (dest_lo),
    .WR_ALL                (wr_all),
    .WR_CHAN               (wr_chan),
    .WR_DATA               (wr_data),
    .QUEUE_EN              (queue_en),
    .OUTPUT_FORCE_GROUND_N (force_ground_n),
    .LOAD_OUTPUTS_N        (load_n),
    .BUSY_N_IN             (busy_n_in),
    .BUSY_N_OUT            (busy_n_out),
    .BUSY_N_OE_N           (busy_n_oe_n),
    .DAC_RD_CHAN           (rd_chan),
    .DAC_RD_WORD           (dac_word),
    .OUTPUT_GROUND_REF     (ground_ref),
    .UPDATE_DONE           (update_done)
  );

  // Clock, update counter and hang guard
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(negedge mclk)
  begin
    cycles++;
    if (update_done === 1'b1)
      n_upd++;
    if (cycles == 20000)
    begin
      n_fail++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Reference correction with truncation and clamping
  function automatic int trim(int x, int g, int o);
    int s;
    s = (((g + 1) * x) >>> 13) + o - 8192;
    return (s > 16383) ? 16383 : ((s < 0) ? 0 : s);
  endfunction

  // Drive one write and mirror it into the model
  task automatic wr(input logic [1:0] d, input bit all, input int ch, input int v);
    u_dgo_host_model.write(d, all, ch[4:0], v[13:0]);
    for (int c = 0; c < 32; c++)
      if (all || c == ch)
      begin
        if (d == `DGO_DEST_INPUT)
          m_in[c] = v;
        else if (d == `DGO_DEST_OFFS)
          m_of[c] = v;
        else if (d == `DGO_DEST_GAIN)
          m_gn[c] = v & 8191;
        if (d != `DGO_DEST_SFR)
        begin
          m_tr[c] = trim(m_in[c], m_gn[c], m_of[c]);
          m_dirty[c] = 1'b1;
        end
      end
  endtask

  // Count busy-low cycles, bounded
  task automatic wait_idle(output int n);
    int k;
    n = 0;
    k = 0;
    while (k < 3 && busy_n_oe_n !== 1'b0)
    begin
      @(negedge mclk);
      k++;
    end
    while (busy_n_oe_n === 1'b0 && n < 700)
    begin
      @(negedge mclk);
      n++;
    end
  endtask

  // Load pulse, model copy of dirty channels, full read-back
  task automatic do_load();
    u_dgo_host_model.set_load(1'b0);
    u_dgo_host_model.set_load(1'b1);
    repeat (3) @(negedge mclk);
  endtask
  task automatic mload();
    for (int c = 0; c < 32; c++)
      if (m_dirty[c])
      begin
        m_dac[c] = m_tr[c];
        m_dirty[c] = 1'b0;
      end
  endtask
  task automatic check_dac();
    for (int c = 0; c < 32; c++)
    begin
      @(negedge mclk);
      rd_chan = c[4:0];
      @(negedge mclk);
      check(32'(dac_word), 32'(m_dac[c]));
    end
  endtask

  // Main sequence
  initial
  begin
    arst_n = 1'b0;
    rd_chan = 5'h00;
    n_fail = 0;
    total_checks = 0;
    cycles = 0;
    n_upd = 0;
    for (int c = 0; c < 32; c++)
    begin
      m_in[c] = 8192;
      m_gn[c] = 8191;
      m_of[c] = 8192;
      m_tr[c] = 8192;
      m_dac[c] = 8192;
      m_dirty[c] = 1'b0;
    end
    void'($urandom(56));
    repeat (20) @(negedge mclk);
    arst_n = 1'b1;
    // Reset state: grounded, not busy, midscale words
    check(32'(ground_ref), 32'h1);
    check(32'(busy_n_oe_n), 32'h1);
    check(32'(busy_n_out), 32'h0);
    check_dac();
    // Load with nothing written: one done pulse, words unchanged
    base = n_upd;
    do_load();
    check(32'(n_upd - base), 32'h1);
    check(32'(ground_ref), 32'h0);
    check_dac();
    // Default gain and offset give identity, single channel busy bound
    wr(`DGO_DEST_INPUT, 1'b0, 5, $urandom_range(16383, 0));
    wait_idle(blen_nq);
    check(32'(blen_nq > 0 && blen_nq <= 33), 32'h1);
    do_load();
    mload();
    check_dac();
    // Random writes over every destination, plus overflow and underflow corners
    for (int i = 0; i < 12; i++)
    begin
      u_dgo_host_model.set_queue(1'($urandom_range(1, 0)));
      wr(2'($urandom_range(3, 0)), ($urandom_range(3, 0) == 0), $urandom_range(31, 0), $urandom_range(16383, 0));
      u_dgo_host_model.pull_busy(1'($urandom_range(1, 0)));
      wait_idle(blen);
      u_dgo_host_model.pull_busy(1'b1);
    end
    wr(`DGO_DEST_OFFS, 1'b0, 7, 16383);
    wr(`DGO_DEST_INPUT, 1'b0, 7, 16383);
    wr(`DGO_DEST_OFFS, 1'b0, 8, 0);
    wr(`DGO_DEST_INPUT, 1'b0, 8, 1);
    wait_idle(blen);
    do_load();
    mload();
    check_dac();
    // Queue overhead lengthens busy
    u_dgo_host_model.set_queue(1'b1);
    wr(`DGO_DEST_GAIN, 1'b0, 9, $urandom_range(8191, 0));
    wait_idle(blen);
    check(32'(blen > blen_nq + 10 && blen <= 53), 32'h1);
    u_dgo_host_model.set_queue(1'b0);
    // All channels at once
    wr(`DGO_DEST_INPUT, 1'b1, 0, $urandom_range(16383, 0));
    wait_idle(blen);
    check(32'(blen > 32 && blen <= 550), 32'h1);
    // Software clear code written by the host for channel 14
    wr(`DGO_DEST_GAIN, 1'b0, 14, 8191);
    wr(`DGO_DEST_OFFS, 1'b0, 14, 2000);
    wr(`DGO_DEST_INPUT, 1'b0, 14, (16384 * (5461 - m_of[14])) / (m_gn[14] + 1));
    wait_idle(blen);
    // Load during busy is stored and done after busy ends
    wr(`DGO_DEST_OFFS, 1'b0, 3, $urandom_range(16383, 0));
    while (busy_n_oe_n !== 1'b0 && cycles < 19000)
      @(negedge mclk);
    base = n_upd;
    do_load();
    check(32'(n_upd - base), 32'h0);
    wait_idle(blen);
    repeat (3) @(negedge mclk);
    check(32'(n_upd - base), 32'h1);
    mload();
    check_dac();
    // Clear grounds outputs, ignores load, keeps words
    wr(`DGO_DEST_INPUT, 1'b0, 12, $urandom_range(16383, 0));
    wait_idle(blen);
    u_dgo_host_model.set_clear(1'b0);
    repeat (2) @(negedge mclk);
    check(32'(ground_ref), 32'h1);
    base = n_upd;
    do_load();
    u_dgo_host_model.set_clear(1'b1);
    repeat (5) @(negedge mclk);
    check(32'(n_upd - base), 32'h0);
    check(32'(ground_ref), 32'h1);
    check_dac();
    do_load();
    mload();
    check(32'(ground_ref), 32'h0);
    check_dac();
    // Outside party holding busy low delays the update
    wr(`DGO_DEST_INPUT, 1'b0, 20, $urandom_range(16383, 0));
    wait_idle(blen);
    u_dgo_host_model.pull_busy(1'b0);
    base = n_upd;
    do_load();
    repeat (10) @(negedge mclk);
    check(32'(n_upd - base), 32'h0);
    u_dgo_host_model.pull_busy(1'b1);
    repeat (3) @(negedge mclk);
    check(32'(n_upd - base), 32'h1);
    mload();
    check_dac();
    // Load held low updates as soon as busy ends
    u_dgo_host_model.set_load(1'b0);
    wr(`DGO_DEST_GAIN, 1'b0, 31, $urandom_range(8191, 0));
    wait_idle(blen);
    base = n_upd;
    repeat (3) @(negedge mclk);
    check(32'(n_upd - base > 0), 32'h1);
    u_dgo_host_model.set_load(1'b1);
    mload();
    check_dac();
    stop_test();
  end
endmodule
